// ===== dv/hbgc_fet_model.sv
// behavioural external mosfets reporting transition start and end
`timescale 1ns/1ps
module hbgc_fet_model (
    // clock
    input wire core_clk,
    // gate commands and slow-fet switch
    input wire [3:0] gateCmd,
    input wire slowFet,
    // transition sense back to the controller
    output reg [3:0] edgeStart,
    output reg [3:0] edgeDone
);
    reg [3:0] d1, d2, d3, d4;
    initial begin
        {d1, d2, d3, d4, edgeStart, edgeDone} = 0;
    end
    // a slow fet never reports the end of its transition
    always @(posedge core_clk) begin
        d1 <= gateCmd;
        d2 <= d1;
        d3 <= d2;
        d4 <= d3;
        edgeStart <= d1 ^ d2;
        edgeDone <= slowFet ? 4'h0 : d3 ^ d4;
    end
endmodule

// ===== dv/hbgc_properties.sv
// port-level assertions for the half-bridge gate controller
`timescale 1ns/1ps
module hbgc_properties (
    // clock and reset
    input wire core_clk,
    input wire rstn,
    // bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // mode and faults
    input wire [2:0] devMode,
    input wire [4:0] faultPin,
    // gates and pump
    input wire [3:0] hsGate,
    input wire [3:0] lsGate,
    input wire [3:0] hsPulldown,
    input wire [3:0] lsPulldown,
    input wire staticDischarge,
    input wire pumpOn
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    fault_off_a: assert property ((|faultPin) [*6] |->
        {hsGate, lsGate} == 8'h00 && {hsPulldown, lsPulldown} == 8'hff)
        else $error("gates not pulled down under fault");
    pd_gate_a: assert property (((hsGate & hsPulldown) | (lsGate & lsPulldown)) == 4'h0)
        else $error("gate driven against its pulldown");
    init_off_a: assert property ((devMode == 3'h0) [*4] |->
        {hsPulldown, lsPulldown} == 8'hff && {hsGate, lsGate} == 8'h00)
        else $error("gates not discharged in init mode");
    pump_idle_a: assert property ((devMode != 3'h1) [*4] |-> !pumpOn)
        else $error("pump running outside normal mode");
    brake_pump_a: assert property (staticDischarge |-> !pumpOn)
        else $error("pump on during braking turn-off");
    park_hs_a: assert property ((devMode == 3'h2 || devMode == 3'h3) && lsGate != 4'h0
        |-> hsPulldown == 4'hf && !pumpOn)
        else $error("high sides not discharged while parking");
    no_shoot_a: assert property ((hsGate & lsGate) == 4'h0)
        else $error("both gates of a bridge on");
endmodule

// ===== dv/tb_half_bridge_gate_ctrl.sv
// self-checking bench for the half-bridge gate controller
`timescale 1ns/1ps
`include "hbgc_defs.vh"
module tb_half_bridge_gate_ctrl;
    reg core_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, vsHighPin, vsLowPin, slow;
    reg [5:2] wb_adr_i;
    reg [3:0] wb_sel_i, pwmPin, genPin, lsSeen, hsSeen;
    reg [31:0] wb_dat_i, rd;
    reg [2:0] devMode;
    reg [4:0] faultPin;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, staticDischarge, pumpOn, pumpNormalLevel, pumpSingleStage, pumpFreqMod;
    wire [3:0] hsGate, lsGate, hsPulldown, lsPulldown, edgeStartPin, edgeDonePin;
    integer error_cnt, tests_run, seed, i, n, sdCnt;
    hbgc_top u_hbgc_top (.*);
    hbgc_fet_model u_fets (.core_clk(core_clk), .gateCmd(hsGate | lsGate),
        .slowFet(slow), .edgeStart(edgeStartPin), .edgeDone(edgeDonePin));
    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        sdCnt = sdCnt + (staticDischarge === 1'b1);
        lsSeen = lsSeen | lsGate;
        hsSeen = hsSeen | hsGate;
    end
    task chk(input [63:0] nm, input [31:0] exp, input [31:0] got);
        begin
            tests_run = tests_run + 1;
            if (exp !== got) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH %0s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", tests_run, error_cnt);
            if (error_cnt == 0 && tests_run > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task settle(input integer c);
        repeat (c) @(negedge core_clk);
    endtask
    // ack and data are read right at the rising edge, before the slave updates them
    task wb(input w, input [3:0] a, input [31:0] d);
        begin
            @(posedge core_clk);
            {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
            wb_adr_i <= a;
            wb_dat_i <= d;
            n = 0;
            @(posedge core_clk);
            while (wb_ack_o !== 1'b1 && n < 50) begin
                @(posedge core_clk);
                n = n + 1;
            end
            if (n >= 50) begin
                error_cnt = error_cnt + 1;
                wrap_up;
            end
            rd = wb_dat_o;
            {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        end
    endtask
    task pulse(input [3:0] p, input integer c);
        begin
            @(posedge core_clk);
            pwmPin <= p;
            repeat (c - 1) @(posedge core_clk);
        end
    endtask
    task brake(input [31:0] c, input [2:0] m, input [3:0] lsExp);
        begin
            @(posedge core_clk);
            sdCnt = 0;
            pwmPin <= $random(seed) | 1;
            wb(1, `HBGC_ADR_CTRL, c);
            devMode <= m;
            settle(30);
            chk("sdis", 11, sdCnt);
            chk("lsOn", lsExp, lsGate);
            chk("pump", 0, pumpOn);
            @(posedge core_clk);
            pwmPin[0] <= 0;
            settle(6);
            chk("lsOff", 0, lsGate);
        end
    endtask
    initial begin
        {error_cnt, tests_run, sdCnt} = 0;
        seed = 32'h6567;
        {wb_cyc_i, wb_stb_i, wb_we_i, vsHighPin, vsLowPin, slow, rstn} = 0;
        {pwmPin, genPin, faultPin, devMode, wb_adr_i, wb_dat_i, lsSeen, hsSeen} = 0;
        wb_sel_i = 4'hf;
        repeat (10) @(posedge core_clk);
        rstn <= 1;
        settle(2);
        chk("fmod", 1, pumpFreqMod);
        chk("pdInit", 8'hff, {hsPulldown, lsPulldown});
        wb(0, `HBGC_ADR_CTRL, 0);
        chk("ctrl", `HBGC_CTRL_RST, rd);
        wb(0, `HBGC_ADR_TIME, 0);
        chk("time", `HBGC_TIME_RST, rd);
        wb(1, `HBGC_ADR_SW1, 32'hffffffff);
        wb(0, `HBGC_ADR_SW1, 0);
        chk("stRo", 0, rd);
        wb(1, 4'hf, 32'h1);
        wb(0, 4'hf, 0);
        chk("unmap", 0, rd);
        $display("test registers done");
        devMode <= `HBGC_M_NORMAL;
        vsHighPin <= 1;
        for (i = 0; i < 8; i = i + 1) begin
            wb(1, `HBGC_ADR_CTRL, 32'h0008f055 | (i << 16));
            settle(5);
            chk("lvl", i[0], pumpNormalLevel);
            chk("stg", i[1], pumpSingleStage);
            chk("fm", i[2], pumpFreqMod);
        end
        @(posedge core_clk);
        vsHighPin <= 0;
        settle(6);
        chk("hyst", 1, pumpSingleStage);
        @(posedge core_clk);
        vsLowPin <= 1;
        settle(6);
        chk("dual", 0, pumpSingleStage);
        wb(1, `HBGC_ADR_CTRL, 32'h000cf000);
        settle(4);
        chk("pd00", 8'hff, {hsPulldown, lsPulldown});
        wb(1, `HBGC_ADR_CTRL, 32'h0004f055);
        settle(4);
        chk("pdcp", 8'hff, {hsPulldown, lsPulldown});
        $display("test pump done");
        // active freewheel on everywhere, so a low-side pulse is a fault only after off-times below FW plus active guard
        wb(1, `HBGC_ADR_CTRL, 32'h000cff55);
        pulse(4'hf, 1);
        n = 0;
        while (hsGate !== 4'hf && n < 40) begin
            @(negedge core_clk);
            n = n + 1;
        end
        chk("lag", 1, n >= 12 && n <= 17);
        lsSeen = 0;
        for (i = 0; i < 12; i = i + 1) begin
            pulse(4'h0, 2 + i % 7);
            pulse(4'hf, 20 + ($unsigned($random(seed)) % 10));
        end
        chk("noAfw", 0, lsSeen);
        pulse(4'h0, 40);
        hsSeen = 0;
        pulse(4'hf, 3);
        pulse(4'h0, 30);
        chk("shortOn", 4'hf, hsSeen);
        wb(0, `HBGC_ADR_SW1, 0);
        chk("xduty", 0, rd);
        lsSeen = 0;
        for (i = 0; i < 3; i = i + 1) begin
            pulse(4'hf, 40);
            pulse(4'h0, 40);
        end
        chk("afw", 4'hf, lsSeen);
        wb(1, `HBGC_ADR_CTRL, 32'h000cf055);
        for (i = 0; i < 6; i = i + 1) begin
            slow <= i > 2;
            pulse(4'hf, 40);
            pulse(4'h0, 40);
            wb(0, `HBGC_ADR_SW1, 0);
            if (i == 2)
                chk("meas", 1, rd[23:16] != 0 && rd[31:24] != 0);
        end
        chk("slowRF", 0, rd[31:16]);
        $display("test pwm done");
        for (i = 0; i < 5; i = i + 1) begin
            pulse(4'hf, 2);
            faultPin <= 5'h1 << i;
            settle(7);
            chk("fltG", 0, {hsGate, lsGate});
            chk("fltP", 8'hff, {hsPulldown, lsPulldown});
            @(posedge core_clk);
            faultPin <= 0;
        end
        $display("test faults done");
        brake(32'h084cf055, `HBGC_M_NORMAL, 4'h7);
        wb(1, `HBGC_ADR_CTRL, 32'h000cf055);
        devMode <= `HBGC_M_INIT;
        sdCnt = 0;
        wb(1, `HBGC_ADR_CTRL, 32'h004cf055);
        settle(20);
        chk("slamInit", 0, sdCnt);
        for (i = 0; i < 2; i = i + 1) begin
            wb(1, `HBGC_ADR_CTRL, 32'h002cf055);
            devMode <= `HBGC_M_NORMAL;
            settle(6);
            brake(32'h002cf055, i ? `HBGC_M_SLEEP : `HBGC_M_STOP, 4'hf);
            chk("parkPd", 8'hf0, {hsPulldown, lsPulldown});
        end
        $display("test braking done");
        wrap_up;
    end
endmodule
bind hbgc_top hbgc_properties u_chk (.*);

// ===== src/hbgc_defs.vh
// constants for the half-bridge gate controller
`ifndef HBGC_DEFS_VH
`define HBGC_DEFS_VH
`define HBGC_ADR_CTRL 4'h0
`define HBGC_ADR_TIME 4'h1
`define HBGC_ADR_STAT 4'h2
`define HBGC_ADR_SW1 4'h4
`define HBGC_CTRL_RST 32'h0004_0000
`define HBGC_TIME_RST 24'h14_0a_0a
`define HBGC_F_LVL 16
`define HBGC_F_STGA 17
`define HBGC_F_FMOD 18
`define HBGC_F_CPON 19
`define HBGC_F_GEN 20
`define HBGC_F_PARK 21
`define HBGC_F_SLAM 22
`define HBGC_M_INIT 3'h0
`define HBGC_M_NORMAL 3'h1
`define HBGC_M_STOP 3'h2
`define HBGC_M_SLEEP 3'h3
`endif

// ===== src/hbgc_top.v
// four half-bridge gate control with wishbone registers
// Operation
// - off-time below active guard drives PWM FET as active, motor as load.
// - high duty: PWM FET lags input by FW guard, opposite FET stays off.
// - no active freewheel when off-time below FW plus active guard.
// - on-time below FW guard: PWM FET driven delayed by one guard time.
// - status shows PWM FET timings, or active FET when generator detect set.
// - rise end not seen before blank time reports rise as zero.
// - fall end not seen before active guard reports fall as zero.
// - extreme duty cycles report all four timings as zero.
// - supply, mode, pump and overvoltage faults force all gates pulled down.
// - pulldown in non-normal modes, low-sides exempt while parking brake.
// - slam request acts only in normal mode.
// - slam turns PWM bridges off and stops pump in the same cycle, for active guard plus one cycle.
// - after that first PWM input drives all four low-sides directly.
// - each low-side can be excluded from slam braking.
// - parking brake on stop/sleep waits active guard plus one cycle, bridges and pump already off outside normal mode.
// - parking: low-side pulldown released, high-side applied, low-sides follow PWM1.
// - gate level bit selects logic-level or normal-level pump regulation.
// - stage bit 0 dual stage, 1 automatic stage by supply hysteresis.
// - frequency modulation bit 0 off, 1 on, reset value 1.
// - active freewheel enable lets opposite FET conduct in off phase.
`timescale 1ns/1ps
`include "hbgc_defs.vh"
module hbgc_top (
    // clock and reset
    input wire core_clk,
    input wire rstn,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:2] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // device mode from the state controller
    input wire [2:0] devMode,
    // pins
    input wire [3:0] pwmPin,
    input wire [3:0] genPin,
    input wire [3:0] edgeStartPin,
    input wire [3:0] edgeDonePin,
    input wire [4:0] faultPin,
    input wire vsHighPin,
    input wire vsLowPin,
    // gate and pump controls
    output reg [3:0] hsGate,
    output reg [3:0] lsGate,
    output reg [3:0] hsPulldown,
    output reg [3:0] lsPulldown,
    output reg staticDischarge,
    output reg pumpOn,
    output reg pumpNormalLevel,
    output reg pumpSingleStage,
    output reg pumpFreqMod
);
    localparam ST_RUN = 2'h0;
    localparam ST_TOFF = 2'h1;
    localparam ST_BRAKE = 2'h2;

    function [7:0] satInc;
        input [7:0] v;
        begin
            satInc = (v == 8'hff) ? v : v + 8'h01;
        end
    endfunction

    reg [31:0] ctrl;
    reg [23:0] timing;
    reg [31:0] swStat [0:3];
    wire [7:0] ccpAct = timing[7:0];
    wire [7:0] ccpFw = timing[15:8];
    wire [7:0] blankT = timing[23:16];

    // two-flop synchronisers for every pin
    reg [18:0] syncA;
    reg [18:0] syncB;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            syncA <= 19'h0;
            syncB <= 19'h0;
        end else begin
            syncA <= {vsLowPin, vsHighPin, faultPin, edgeDonePin, edgeStartPin, genPin};
            syncB <= syncA;
        end
    end
    wire [3:0] gen = syncB[3:0];
    wire [3:0] eStart = syncB[7:4];
    wire [3:0] eDone = syncB[11:8];
    wire anyFault = |syncB[16:12];
    wire vsHigh = syncB[17];
    wire vsLow = syncB[18];
    reg [3:0] pwmA;
    reg [3:0] pwm;
    reg [3:0] pwmQ;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pwmA <= 4'h0;
            pwm <= 4'h0;
            pwmQ <= 4'h0;
        end else begin
            pwmA <= pwmPin;
            pwm <= pwmA;
            pwmQ <= pwm;
        end
    end

    // per-bridge pulse shaping
    reg [7:0] onCnt [0:3];
    reg [7:0] offCnt [0:3];
    reg [7:0] riseTmr [0:3];
    reg [7:0] fallTmr [0:3];
    reg [3:0] riseArm;
    reg [3:0] fallArm;
    reg [3:0] pwmDel;
    reg [3:0] shortOn;
    reg [3:0] shortOff;
    reg [3:0] noAfw;
    // each process keeps its own loop index so no variable has two drivers
    always @(posedge core_clk or negedge rstn) begin : pulse_shape
        integer i;
        if (!rstn) begin
            for (i = 0; i < 4; i = i + 1) begin
                onCnt[i] <= 8'h0;
                offCnt[i] <= 8'h0;
                riseTmr[i] <= 8'h0;
                fallTmr[i] <= 8'h0;
            end
            riseArm <= 4'h0;
            fallArm <= 4'h0;
            pwmDel <= 4'h0;
            shortOn <= 4'h0;
            shortOff <= 4'h0;
            noAfw <= 4'hf;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                onCnt[i] <= pwm[i] ? (pwmQ[i] ? satInc(onCnt[i]) : 8'h01) : onCnt[i];
                offCnt[i] <= !pwm[i] ? (!pwmQ[i] ? satInc(offCnt[i]) : 8'h01) : offCnt[i];
                // separate timers per edge so pulses shorter than the lag survive
                if (pwm[i] && !pwmQ[i]) begin
                    riseArm[i] <= 1'b1;
                    riseTmr[i] <= 8'h0;
                    shortOff[i] <= offCnt[i] < ccpAct;
                    noAfw[i] <= {1'b0, offCnt[i]} < ({1'b0, ccpFw} + {1'b0, ccpAct});
                end else if (riseArm[i]) begin
                    riseTmr[i] <= satInc(riseTmr[i]);
                end
                if (!pwm[i] && pwmQ[i]) begin
                    fallArm[i] <= 1'b1;
                    fallTmr[i] <= 8'h0;
                    shortOn[i] <= onCnt[i] < ccpFw;
                end else if (fallArm[i]) begin
                    fallTmr[i] <= satInc(fallTmr[i]);
                end
                // command lags the input by one FW guard time
                if (riseArm[i] && riseTmr[i] >= ccpFw) begin
                    pwmDel[i] <= 1'b1;
                    riseArm[i] <= 1'b0;
                end else if (fallArm[i] && fallTmr[i] >= ccpFw) begin
                    pwmDel[i] <= 1'b0;
                    fallArm[i] <= 1'b0;
                end
            end
        end
    end

    // opposite FET conducts only with both raw and lagged command low
    wire [3:0] afwEn = ctrl[11:8];
    wire [3:0] pwmAllow = ctrl[15:12];
    wire [3:0] oppCmd = afwEn & ~noAfw & ~shortOn & ~shortOff & ~pwm & ~pwmDel;
    wire [3:0] extreme = shortOn | shortOff;

    // switching time measurement
    reg [1:0] mPhase [0:3];
    reg [7:0] mCnt [0:3];
    reg [7:0] mDly [0:3];
    reg [3:0] cmdQ;
    reg [3:0] measCmd;
    always @* begin : meas_sel
        integer i;
        i = 0;
        for (i = 0; i < 4; i = i + 1) begin
            measCmd[i] = (ctrl[`HBGC_F_GEN] && gen[i]) ? oppCmd[i] : pwmDel[i];
        end
    end
    always @(posedge core_clk or negedge rstn) begin : meas_time
        integer i;
        if (!rstn) begin
            for (i = 0; i < 4; i = i + 1) begin
                mPhase[i] <= 2'h0;
                mCnt[i] <= 8'h0;
                mDly[i] <= 8'h0;
                swStat[i] <= 32'h0;
            end
            cmdQ <= 4'h0;
        end else begin
            cmdQ <= measCmd;
            for (i = 0; i < 4; i = i + 1) begin
                mCnt[i] <= satInc(mCnt[i]);
                if (extreme[i]) begin
                    swStat[i] <= 32'h0;
                    mPhase[i] <= 2'h0;
                end else if (measCmd[i] != cmdQ[i]) begin
                    mPhase[i] <= 2'h1;
                    mCnt[i] <= 8'h0;
                end else if (mPhase[i] == 2'h1 && eStart[i]) begin
                    mDly[i] <= mCnt[i];
                    mCnt[i] <= 8'h0;
                    mPhase[i] <= 2'h2;
                end else if (mPhase[i] == 2'h2 && cmdQ[i]) begin
                    if (eDone[i]) begin
                        swStat[i][7:0] <= mDly[i];
                        swStat[i][23:16] <= mCnt[i];
                        mPhase[i] <= 2'h0;
                    end else if (mCnt[i] >= blankT) begin
                        swStat[i][7:0] <= mDly[i];
                        swStat[i][23:16] <= 8'h0;
                        mPhase[i] <= 2'h0;
                    end
                end else if (mPhase[i] == 2'h2) begin
                    if (eDone[i]) begin
                        swStat[i][15:8] <= mDly[i];
                        swStat[i][31:24] <= mCnt[i];
                        mPhase[i] <= 2'h0;
                    end else if (mCnt[i] >= ccpAct) begin
                        swStat[i][15:8] <= mDly[i];
                        swStat[i][31:24] <= 8'h0;
                        mPhase[i] <= 2'h0;
                    end
                end
            end
        end
    end

    // braking sequencer shared by slam and parking
    wire isNormal = devMode == `HBGC_M_NORMAL;
    wire slamReq = ctrl[`HBGC_F_SLAM] && isNormal;
    wire parkReq = ctrl[`HBGC_F_PARK] &&
        (devMode == `HBGC_M_STOP || devMode == `HBGC_M_SLEEP);
    reg [1:0] bState;
    reg [7:0] bCnt;
    reg parking;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bState <= ST_RUN;
            bCnt <= 8'h0;
            parking <= 1'b0;
        end else begin
            case (bState)
                ST_RUN: begin
                    bCnt <= 8'h0;
                    if (slamReq || parkReq) begin
                        bState <= ST_TOFF;
                        parking <= parkReq;
                    end
                end
                ST_TOFF: begin
                    bCnt <= satInc(bCnt);
                    if (!(slamReq || parkReq)) begin
                        bState <= ST_RUN;
                    end else if (bCnt >= ccpAct) begin
                        bState <= ST_BRAKE;
                    end
                end
                ST_BRAKE: begin
                    if (!(slamReq || parkReq)) begin
                        bState <= ST_RUN;
                    end
                end
                default: bState <= ST_RUN;
            endcase
        end
    end

    // pump stage hysteresis
    reg singleStage;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            singleStage <= 1'b0;
        end else if (!ctrl[`HBGC_F_STGA]) begin
            singleStage <= 1'b0;
        end else if (vsHigh) begin
            singleStage <= 1'b1;
        end else if (vsLow) begin
            singleStage <= 1'b0;
        end
    end

    // gate output decode
    reg [3:0] nextHs;
    reg [3:0] nextLs;
    reg [3:0] nextHsPd;
    reg [3:0] nextLsPd;
    reg [1:0] bm;
    reg forcedOff;
    always @* begin : gate_dec
        integer i;
        i = 0;
        nextHs = 4'h0;
        nextLs = 4'h0;
        forcedOff = anyFault || (isNormal && !ctrl[`HBGC_F_CPON]);
        nextHsPd = 4'hf;
        nextLsPd = 4'hf;
        for (i = 0; i < 4; i = i + 1) begin
            bm = ctrl[2*i +: 2];
            if (bState == ST_RUN && isNormal && !forcedOff && bm != 2'h0) begin
                nextHsPd[i] = 1'b0;
                nextLsPd[i] = 1'b0;
                if (bm == 2'h1) begin
                    nextHs[i] = pwmDel[i] & pwmAllow[i];
                    nextLs[i] = oppCmd[i] & pwmAllow[i];
                end else if (bm == 2'h2) begin
                    nextLs[i] = pwmDel[i] & pwmAllow[i];
                    nextHs[i] = oppCmd[i] & pwmAllow[i];
                end
            end
        end
        if (bState == ST_BRAKE && !anyFault) begin
            if (parking) begin
                nextLsPd = 4'h0;
                nextLs = {4{pwm[0]}};
            end else begin
                nextLsPd = ctrl[27:24];
                nextLs = {4{pwm[0]}} & ~ctrl[27:24];
            end
        end
    end

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hsGate <= 4'h0;
            lsGate <= 4'h0;
            hsPulldown <= 4'hf;
            lsPulldown <= 4'hf;
            staticDischarge <= 1'b0;
            pumpOn <= 1'b0;
            pumpNormalLevel <= 1'b0;
            pumpSingleStage <= 1'b0;
            pumpFreqMod <= 1'b1;
        end else begin
            hsGate <= nextHs;
            lsGate <= nextLs;
            hsPulldown <= nextHsPd;
            lsPulldown <= nextLsPd;
            staticDischarge <= bState == ST_TOFF;
            pumpOn <= ctrl[`HBGC_F_CPON] && isNormal && bState == ST_RUN;
            pumpNormalLevel <= ctrl[`HBGC_F_LVL];
            pumpSingleStage <= singleStage;
            pumpFreqMod <= ctrl[`HBGC_F_FMOD];
        end
    end

    // wishbone slave, one wait state, ack drops after one cycle
    wire wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    reg [31:0] rdData;
    always @* begin
        case (wb_adr_i)
            `HBGC_ADR_CTRL: rdData = ctrl;
            `HBGC_ADR_TIME: rdData = {8'h0, timing};
            `HBGC_ADR_STAT: rdData = {20'h0, extreme, bState, singleStage, pumpOn,
                                      2'h0, parking, anyFault};
            4'h4, 4'h5, 4'h6, 4'h7: rdData = swStat[wb_adr_i[3:2]];
            default: rdData = 32'h0;
        endcase
    end
    integer b;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= `HBGC_CTRL_RST;
            timing <= `HBGC_TIME_RST;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wbReq;
            wb_dat_o <= wbReq ? rdData : 32'h0;
            // writes land on the edge that sees ack, when the master completes
            if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
                for (b = 0; b < 4; b = b + 1) begin
                    if (wb_sel_i[b] && wb_adr_i == `HBGC_ADR_CTRL) begin
                        ctrl[8*b +: 8] <= wb_dat_i[8*b +: 8];
                    end
                    if (wb_sel_i[b] && wb_adr_i == `HBGC_ADR_TIME && b < 3) begin
                        timing[8*b +: 8] <= wb_dat_i[8*b +: 8];
                    end
                end
            end
        end
    end
endmodule
